/* shared/loudness_pkg.sv */
package loudness_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Datapath widths
	localparam int NCH = 5;
	localparam int SW = 24;
	localparam int DW = 40;
	localparam int CW = 32;
	localparam int CFRAC = 28;
	localparam int AW = DW + CW + 4;
	localparam int IN_SHIFT = 8;
	localparam int SQ_SHIFT = 24;
	localparam int GW = 9;
	localparam int GFRAC = 8;
	localparam int EW = 80;
	localparam int LW = 24;
	localparam int BCW = 24;
	localparam int SCW = 16;
	localparam int BW = 9;

	////////////////////////////////////////////////////////////////////////////
	// Channel index order: 0 left, 1 right, 2 centre, 3 rear left, 4 rear right
	localparam int CH_LEFT = 0;
	localparam int CH_RIGHT = 1;
	localparam int CH_CENTRE = 2;
	localparam int CH_REAR_LEFT = 3;
	localparam int CH_REAR_RIGHT = 4;

	// Channel gains, 8 fractional bits: 1.0 front, 1.41 rear
	localparam logic [NCH-1:0][GW-1:0] CH_WEIGHT_Q8 = {9'h169, 9'h169, 9'h100, 9'h100, 9'h100};

	////////////////////////////////////////////////////////////////////////////
	// Timing of the gating blocks, counted in input frames
	localparam int SAMPLE_RATE_HZ = 48000;
	localparam int BLOCK_MS = 400;
	localparam int BLOCK_SAMPLES = (SAMPLE_RATE_HZ * BLOCK_MS + 500) / 1000;
	localparam int QUARTERS = 4;
	localparam int QUARTER_SAMPLES = BLOCK_SAMPLES / QUARTERS;

	////////////////////////////////////////////////////////////////////////////
	// Filter coefficients, signed, 28 fractional bits, valid at 48 kHz only
	localparam logic signed [CW-1:0] SHELF_B0 = 32'sh188fdf16;
	localparam logic signed [CW-1:0] SHELF_B1 = 32'shd4eecffa;
	localparam logic signed [CW-1:0] SHELF_B2 = 32'sh132c9df1;
	localparam logic signed [CW-1:0] SHELF_A1 = 32'she4f30f3e;
	localparam logic signed [CW-1:0] SHELF_A2 = 32'sh0bb83dc3;
	localparam logic signed [CW-1:0] HPF_B0 = 32'sh10000000;
	localparam logic signed [CW-1:0] HPF_B1 = 32'she0000000;
	localparam logic signed [CW-1:0] HPF_B2 = 32'sh10000000;
	localparam logic signed [CW-1:0] HPF_A1 = 32'she028c400;
	localparam logic signed [CW-1:0] HPF_A2 = 32'sh0fd75600;

	////////////////////////////////////////////////////////////////////////////
	// Loudness arithmetic, values in 1/256 loudness unit
	localparam int LFRAC = 8;
	// -0.691 minus the level of a full scale square at the energy scale used
	localparam logic signed [LW-1:0] FS_OFFSET_Q = 24'shff8ceb;
	localparam logic signed [LW-1:0] ABS_THR_Q = 24'shffba00;
	localparam logic signed [LW-1:0] REL_DROP_Q = 24'sh000a00;
	localparam logic signed [LW-1:0] QUARTER_ADJ_Q = 24'sh000605;
	localparam logic signed [LW-1:0] LOG_ZERO_Q = 24'sh800000;
	localparam logic signed [LW-1:0] LSB_Q = 24'sh000001;
	localparam logic [31:0] LOG2_TO_DB_Q16 = 32'h000302a3;
	localparam logic [31:0] LOG_CORR_Q16 = 32'h000058b9;
	localparam int LOG_FRAC = 16;

	// Histogram of block loudness above the absolute gate, 0.25 unit per bin
	localparam int BIN_SHIFT = 6;
	localparam logic signed [LW-1:0] BIN_ROUND_Q = 24'sh00003f;
	localparam int NBINS = 320;

	////////////////////////////////////////////////////////////////////////////
	// Input frame buffer
	localparam int FIFO_DEPTH = 2;
	localparam int FIFO_AW = 1;

endpackage

/* verif/frame_source.sv */
module frame_source (
	input wire logic mclk_i,
	input wire logic frame_ready_i,
	output logic frame_valid_o,
	output logic signed [loudness_pkg::SW-1:0] smp_o [loudness_pkg::NCH]
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		frame_valid_o = 1'b0;
		foreach (smp_o[i]) smp_o[i] = '0;
	end

	// Released lines show the inverse of the last frame, so stale data is never read as good
	task automatic rest();
		frame_valid_o = 1'b0;
		foreach (smp_o[i]) smp_o[i] = ~smp_o[i];
	endtask

	// Valid stays up between back to back frames; a gap drops it first
	task automatic send(input logic signed [loudness_pkg::SW-1:0] d [loudness_pkg::NCH], input int gap);
		if (gap > 0) begin
			rest();
			repeat (gap) @(posedge mclk_i);
			#1;
		end
		frame_valid_o = 1'b1;
		smp_o = d;
		do @(posedge mclk_i); while (frame_ready_i !== 1'b1);
		#1;
	endtask
endmodule

/* verif/loudness_meter_chk.sv */
module loudness_meter_chk #(
	parameter int QUARTER_SAMPLES = loudness_pkg::QUARTER_SAMPLES
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic frame_valid_i,
	input wire logic frame_ready_o,
	input wire logic meas_end_i,
	input wire logic signed [loudness_pkg::LW-1:0] gated_loudness_o,
	input wire logic signed [loudness_pkg::LW-1:0] ungated_loudness_o,
	input wire logic block_valid_o,
	input wire logic gated_invalid_o,
	input wire logic ungated_invalid_o,
	input wire logic result_valid_o,
	input wire logic gate_busy_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [15:0] taken_r;
	logic [15:0] blk_r;
	logic [9:0] busy_r;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			taken_r <= 16'h0000;
		end else if (frame_valid_i && frame_ready_o) begin
			taken_r <= taken_r + 16'h0001;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			blk_r <= 16'h0000;
		end else if (block_valid_o) begin
			blk_r <= blk_r + 16'h0001;
		end
	end

	// Length of the last scan, held after it ends so the result pulse can see it
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i || (meas_end_i && !gate_busy_o)) begin
			busy_r <= 10'h000;
		end else if (gate_busy_o) begin
			busy_r <= busy_r + 10'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	sequence s_take;
		meas_end_i && !gate_busy_o;
	endsequence
	sequence s_answer;
		##[643:643] result_valid_o;
	endsequence

	a_reset_vals: assert property (disable iff (1'b0) !rst_b_i |=> gated_invalid_o && ungated_invalid_o
		&& !result_valid_o && !block_valid_o && !gate_busy_o && gated_loudness_o == loudness_pkg::LOG_ZERO_Q)
		else $error("result outputs wrong after reset");
	a_busy_rise: assert property (s_take |=> gate_busy_o)
		else $error("scan did not start");
	a_result_time: assert property (s_take |-> s_answer)
		else $error("result not at its fixed delay");
	a_busy_len: assert property (result_valid_o |-> busy_r == 10'h282)
		else $error("scan length wrong");
	a_result_pulse: assert property (result_valid_o |=> !result_valid_o && !gate_busy_o)
		else $error("result pulse too long");
	a_result_hold: assert property ($past(rst_b_i) && !result_valid_o |-> $stable(gated_loudness_o)
		&& $stable(gated_invalid_o) && $stable(ungated_loudness_o))
		else $error("result changed without pulse");
	a_invalid_code: assert property (result_valid_o && gated_invalid_o |-> gated_loudness_o == loudness_pkg::LOG_ZERO_Q)
		else $error("invalid result code wrong");
	a_early_ungated: assert property (result_valid_o && taken_r < 4 * QUARTER_SAMPLES |-> ungated_invalid_o)
		else $error("ungated valid before a full block");
	a_block_count: assert property (block_valid_o |-> (blk_r + 16'h0004) * QUARTER_SAMPLES <= taken_r)
		else $error("block before enough frames");
	a_block_pulse: assert property (block_valid_o |=> !block_valid_o)
		else $error("block pulse too long");
endmodule

bind loudness_meter loudness_meter_chk #(.QUARTER_SAMPLES(QUARTER_SAMPLES)) chk_u (
	.mclk_i(mclk_i),
	.rst_b_i(rst_b_i),
	.frame_valid_i(frame_valid_i),
	.frame_ready_o(frame_ready_o),
	.meas_end_i(meas_end_i),
	.gated_loudness_o(gated_loudness_o),
	.ungated_loudness_o(ungated_loudness_o),
	.block_valid_o(block_valid_o),
	.gated_invalid_o(gated_invalid_o),
	.ungated_invalid_o(ungated_invalid_o),
	.result_valid_o(result_valid_o),
	.gate_busy_o(gate_busy_o)
);

/* verif/loudness_meter_tb.sv */
module loudness_meter_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int QS = 8;
	logic mclk = 1'b0;
	logic rst_b;
	logic meas_end = 1'b0;
	logic [loudness_pkg::NCH-1:0] en;
	logic fv, rdy, bv, rv, gi, ui, busy;
	logic signed [loudness_pkg::SW-1:0] smp [loudness_pkg::NCH];
	logic signed [loudness_pkg::LW-1:0] bl, gl, ul;
	int fails = 0;
	int tests_run = 0;
	int rdy_lo = 0;
	real st[5][8];
	real qe[$];
	real blk[$];
	real pend[$];
	real qacc, ph, mx;
	int nf;
	real chs[5] = '{1.0, 0.5, 0.7, 0.25, 0.35};

	always #2.5 mclk = ~mclk;

	frame_source src_u (.mclk_i(mclk), .frame_ready_i(rdy), .frame_valid_o(fv), .smp_o(smp));
	loudness_meter #(.QUARTER_SAMPLES(QS)) dut_u (.mclk_i(mclk), .rst_b_i(rst_b), .frame_valid_i(fv),
		.frame_ready_o(rdy), .left_channel_i(smp[0]), .right_channel_i(smp[1]), .centre_channel_i(smp[2]),
		.rear_left_channel_i(smp[3]), .rear_right_channel_i(smp[4]), .ch_enable_i(en), .meas_end_i(meas_end),
		.block_loudness_o(bl), .block_valid_o(bv), .gated_loudness_o(gl), .ungated_loudness_o(ul),
		.gated_invalid_o(gi), .ungated_invalid_o(ui), .result_valid_o(rv), .gate_busy_o(busy));

	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cmp_l(input logic signed [loudness_pkg::LW-1:0] got, input real exp, input real tol);
		logic signed [loudness_pkg::LW-1:0] e;
		e = loudness_pkg::LW'($rtoi(exp * 256.0));
		tests_run++;
		if ($isunknown(got) || $itor(got) - exp * 256.0 > tol * 256.0 || exp * 256.0 - $itor(got) > tol * 256.0) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, e);
		end
	endtask

	task automatic cmp_b(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_n(input int got, input int exp);
		tests_run++;
		if (got != exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	function automatic real lk(input real e);
		return e > 0.0 ? -0.691 + 10.0 * $log10(e) : -999.0;
	endfunction

	function automatic real bq(input int c, int o, real x, real b0, real b1, real b2, real a1, real a2);
		real y;
		y = b0 * x + b1 * st[c][o] + b2 * st[c][o+1] - a1 * st[c][o+2] - a2 * st[c][o+3];
		st[c][o+1] = st[c][o];
		st[c][o] = x;
		st[c][o+3] = st[c][o+2];
		st[c][o+2] = y;
		return y;
	endfunction

	function automatic real gated(output logic inv);
		real s, t;
		int k;
		s = 0.0;
		k = 0;
		foreach (blk[j]) if (lk(blk[j]) > -70.0) begin s += blk[j]; k++; end
		inv = (k == 0);
		if (k == 0) return 0.0;
		t = lk(s / k) - 10.0;
		s = 0.0;
		k = 0;
		foreach (blk[j]) if (lk(blk[j]) > -70.0 && lk(blk[j]) > t) begin s += blk[j]; k++; end
		return lk(s / k);
	endfunction

	// Reference model runs each frame as it is offered; blocks queue up for the monitor
	task automatic gen(input real a, input int n);
		logic signed [loudness_pkg::SW-1:0] d [loudness_pkg::NCH];
		real y, e;
		for (int i = 0; i < n; i++) begin
			e = 0.0;
			for (int c = 0; c < 5; c++) begin
				d[c] = loudness_pkg::SW'($rtoi(a * chs[c] * 8388607.0 * $sin(ph * 6.283185307 * 997.0 / 48000.0 + c)));
				if (en[c] === 1'b1) begin
					y = bq(c, 0, d[c] / 8388608.0, 1.53512485958697, -2.69169618940638, 1.19839281085285,
						-1.69065929318241, 0.73248077421585);
					y = bq(c, 4, y, 1.0, -2.0, 1.0, -1.99004745483398, 0.99007225036621);
					e += (c > 2 ? 1.41 : 1.0) * y * y;
				end
			end
			ph += 1.0;
			qacc += e;
			nf++;
			if (nf == QS) begin
				qe.push_back(qacc);
				qacc = 0.0;
				nf = 0;
				if (qe.size() >= 4) begin
					y = (qe[$] + qe[$-1] + qe[$-2] + qe[$-3]) / (4.0 * QS);
					blk.push_back(y);
					pend.push_back(y);
				end
			end
			src_u.send(d, (i % 16 == 15) ? 25 : 0);
		end
	endtask

	always @(posedge mclk) begin
		if (rst_b && rdy === 1'b0) rdy_lo++;
		if (rst_b && bv === 1'b1) begin
			mx = pend.size() > 0 ? lk(pend.pop_front()) : 99.0;
			if (mx > -60.0) cmp_l(bl, mx, 0.2);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic do_reset(input logic [4:0] m);
		rst_b = 1'b0;
		en = m;
		qe.delete();
		blk.delete();
		pend.delete();
		qacc = 0.0;
		nf = 0;
		ph = 0.0;
		foreach (st[c, k]) st[c][k] = 0.0;
		repeat (2) @(posedge mclk);
		#1 rst_b = 1'b1;
	endtask

	// A frame takes at most 20 cycles, so three frames' worth drains the buffer
	task automatic settle();
		src_u.rest();
		repeat (66) @(posedge mclk);
		#1;
		cmp_n(pend.size(), 0);
	endtask

	task automatic get_result(input logic poke);
		logic gi_e;
		real g, s;
		int n;
		g = gated(gi_e);
		s = 0.0;
		foreach (qe[q]) s += qe[q];
		meas_end = 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			#1 meas_end = poke && n == 4;
			n++;
		end while (rv !== 1'b1 && n < 1000);
		cmp_n(n, 643);
		cmp_b(gi, gi_e);
		cmp_b(ui, qe.size() < 4);
		if (gi_e === 1'b0) cmp_l(gl, g, 0.5);
		else cmp_l(gl, -32768.0, 0.0);
		if (qe.size() >= 4 && s > 0.0) cmp_l(ul, lk(s / (qe.size() * QS)), 0.2);
		else if (qe.size() >= 4) cmp_l(ul, -32768.0, 0.0);
	endtask

	task automatic t_reset_vals();
		do_reset(5'h1f);
		cmp_b(rdy, 1'b1);
		cmp_b(busy, 1'b0);
		cmp_b(gi, 1'b1);
		cmp_b(ui, 1'b1);
		cmp_l(gl, -32768.0, 0.0);
		cmp_l(ul, -32768.0, 0.0);
		cmp_l(bl, -32768.0, 0.0);
	endtask

	task automatic t_idle();
		int n;
		do_reset(5'h1f);
		get_result(1'b1);
		n = 0;
		repeat (700) begin
			@(posedge mclk);
			#1;
			if (rv === 1'b1) n++;
		end
		cmp_n(n, 0);
	endtask

	task automatic t_silence();
		do_reset(5'h1f);
		gen(0.0, 4 * QS);
		settle();
		get_result(1'b0);
	endtask

	// Loud, silent, then very quiet stretch: only the loud blocks may survive both gates
	task automatic t_gating();
		do_reset(5'h1f);
		rdy_lo = 0;
		gen(0.5, 8 * QS);
		gen(0.0, 4 * QS);
		gen(0.01, 4 * QS);
		gen(0.5, 3);
		settle();
		cmp_b(rdy_lo > 0, 1'b1);
		get_result(1'b0);
	endtask

	task automatic t_single();
		do_reset(5'h01);
		gen(0.5, 6 * QS);
		settle();
		get_result(1'b0);
	endtask

	initial begin
		t_reset_vals();
		t_idle();
		t_silence();
		t_gating();
		t_single();
		print_verdict();
	end

	initial begin
		#(60000 * 5);
		fails++;
		print_verdict();
	end
endmodule

/* verilog/loudness_meter.sv */
module loudness_meter #(
	parameter int QUARTER_SAMPLES = loudness_pkg::QUARTER_SAMPLES
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic frame_valid_i,
	output logic frame_ready_o,
	input wire logic signed [loudness_pkg::SW-1:0] left_channel_i,
	input wire logic signed [loudness_pkg::SW-1:0] right_channel_i,
	input wire logic signed [loudness_pkg::SW-1:0] centre_channel_i,
	input wire logic signed [loudness_pkg::SW-1:0] rear_left_channel_i,
	input wire logic signed [loudness_pkg::SW-1:0] rear_right_channel_i,
	input wire logic [loudness_pkg::NCH-1:0] ch_enable_i,
	input wire logic meas_end_i,
	output logic signed [loudness_pkg::LW-1:0] block_loudness_o,
	output logic block_valid_o,
	output logic signed [loudness_pkg::LW-1:0] gated_loudness_o,
	output logic signed [loudness_pkg::LW-1:0] ungated_loudness_o,
	output logic gated_invalid_o,
	output logic ungated_invalid_o,
	output logic result_valid_o,
	output logic gate_busy_o
);

	localparam int FW = loudness_pkg::NCH * loudness_pkg::SW;

	typedef logic signed [loudness_pkg::DW-1:0] dat_type;
	typedef logic signed [loudness_pkg::CW-1:0] coef_type;
	typedef logic [loudness_pkg::EW-1:0] energy_type;
	typedef logic signed [loudness_pkg::LW-1:0] loud_type;

	typedef enum logic [6:0] {
		F_IDLE = 7'b0000001,
		F_SHELF = 7'b0000010,
		F_HPF = 7'b0000100,
		F_ACC = 7'b0001000,
		F_QTR = 7'b0010000,
		F_BLK = 7'b0100000,
		F_HIST = 7'b1000000
	} frame_state_type;

	typedef enum logic [4:0] {
		G_IDLE = 5'b00001,
		G_SUM1 = 5'b00010,
		G_THR = 5'b00100,
		G_SUM2 = 5'b01000,
		G_OUT = 5'b10000
	} gate_state_type;

	////////////////////////////////////////////////////////////////////////////
	// Arithmetic helpers

	// Direct form I section; the leading feedback term is one
	function automatic dat_type biquad(input dat_type x, input dat_type x1, input dat_type x2,
		input dat_type y1, input dat_type y2, input coef_type b0, input coef_type b1,
		input coef_type b2, input coef_type a1, input coef_type a2);
		logic signed [loudness_pkg::AW-1:0] acc;
		acc = x * b0 + x1 * b1 + x2 * b2 - y1 * a1 - y2 * a2;
		return dat_type'(acc >>> loudness_pkg::CFRAC);
	endfunction

	// Ten times log10 in 1/256 units; a doubling adds 770 or 771, close to 3.01 units
	function automatic loud_type log10x10(input energy_type x);
		int p;
		energy_type n;
		logic [15:0] f;
		logic [31:0] corr;
		logic [47:0] l2;
		logic [63:0] db;
		p = 0;
		for (int i = 0; i < loudness_pkg::EW; i++) begin
			if (x[i]) begin
				p = i;
			end
		end
		n = x << (loudness_pkg::EW - 1 - p);
		f = n[loudness_pkg::EW-2 -: 16];
		// Parabolic bend of the mantissa keeps the error near 0.03 dB
		corr = (32'(f) * (32'h00010000 - 32'(f))) >> loudness_pkg::LOG_FRAC;
		corr = (corr * loudness_pkg::LOG_CORR_Q16) >> loudness_pkg::LOG_FRAC;
		l2 = (48'(p) << loudness_pkg::LOG_FRAC) + 48'(f) + 48'(corr);
		db = (64'(l2) * 64'(loudness_pkg::LOG2_TO_DB_Q16)) >> (2 * loudness_pkg::LOG_FRAC - loudness_pkg::LFRAC);
		if (x == '0) begin
			return loudness_pkg::LOG_ZERO_Q;
		end
		return loud_type'(db[loudness_pkg::LW-1:0]);
	endfunction

	// Offset for a mean over one whole block
	localparam loud_type BLK_OFFSET_Q = loudness_pkg::FS_OFFSET_Q
		- log10x10(energy_type'(loudness_pkg::QUARTERS * QUARTER_SAMPLES));

	////////////////////////////////////////////////////////////////////////////
	// Input frame buffer

	logic [FW-1:0] fifo_mem [loudness_pkg::FIFO_DEPTH];
	logic [loudness_pkg::FIFO_AW-1:0] wr_ptr_r;
	logic [loudness_pkg::FIFO_AW-1:0] rd_ptr_r;
	logic [loudness_pkg::FIFO_AW:0] fifo_cnt_r;
	logic signed [loudness_pkg::SW-1:0] frame_r [loudness_pkg::NCH];
	logic push;
	logic pop;
	frame_state_type fs_r;

	assign frame_ready_o = (fifo_cnt_r != (loudness_pkg::FIFO_AW + 1)'(loudness_pkg::FIFO_DEPTH));
	assign push = frame_valid_i && frame_ready_o;
	assign pop = (fs_r == F_IDLE) && (fifo_cnt_r != '0);

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			fifo_cnt_r <= '0;
			for (int c = 0; c < loudness_pkg::NCH; c++) begin
				frame_r[c] <= '0;
			end
		end else begin
			if (push) begin
				fifo_mem[wr_ptr_r] <= {rear_right_channel_i, rear_left_channel_i, centre_channel_i,
					right_channel_i, left_channel_i};
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				for (int c = 0; c < loudness_pkg::NCH; c++) begin
					frame_r[c] <= fifo_mem[rd_ptr_r][c*loudness_pkg::SW +: loudness_pkg::SW];
				end
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				fifo_cnt_r <= fifo_cnt_r + 1'b1;
			end else if (pop && !push) begin
				fifo_cnt_r <= fifo_cnt_r - 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame sequencer: channels are processed one after another

	logic [2:0] ch_r;
	logic [loudness_pkg::SCW-1:0] scount_r;
	logic [1:0] qfill_r;
	logic quarter_end;
	logic last_ch;

	assign quarter_end = (scount_r == loudness_pkg::SCW'(QUARTER_SAMPLES - 1));
	assign last_ch = (ch_r == 3'(loudness_pkg::NCH - 1));

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			fs_r <= F_IDLE;
			ch_r <= '0;
		end else begin
			unique case (fs_r)
				F_IDLE: begin
					if (pop) begin
						ch_r <= '0;
						fs_r <= F_SHELF;
					end
				end
				F_SHELF: begin
					if (ch_enable_i[ch_r]) begin
						fs_r <= F_HPF;
					end else if (last_ch) begin
						fs_r <= F_QTR;
					end else begin
						ch_r <= ch_r + 3'h1;
					end
				end
				F_HPF: fs_r <= F_ACC;
				F_ACC: begin
					if (last_ch) begin
						fs_r <= F_QTR;
					end else begin
						ch_r <= ch_r + 3'h1;
						fs_r <= F_SHELF;
					end
				end
				F_QTR: fs_r <= (quarter_end && qfill_r == 2'h3) ? F_BLK : F_IDLE;
				F_BLK: fs_r <= F_HIST;
				F_HIST: fs_r <= F_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Weighting filters

	dat_type sx1 [loudness_pkg::NCH];
	dat_type sx2 [loudness_pkg::NCH];
	dat_type sy1 [loudness_pkg::NCH];
	dat_type sy2 [loudness_pkg::NCH];
	dat_type hx1 [loudness_pkg::NCH];
	dat_type hx2 [loudness_pkg::NCH];
	dat_type hy1 [loudness_pkg::NCH];
	dat_type hy2 [loudness_pkg::NCH];
	dat_type x_c;
	dat_type shelf_c;
	dat_type hp_c;
	dat_type shelf_y_r;
	dat_type hp_y_r;

	always_comb begin
		x_c = {{(loudness_pkg::DW - loudness_pkg::SW - loudness_pkg::IN_SHIFT){frame_r[ch_r][loudness_pkg::SW-1]}},
			frame_r[ch_r], {loudness_pkg::IN_SHIFT{1'b0}}};
		// Quantised constants, exact only at 48 kHz; other rates need a new set
		shelf_c = biquad(x_c, sx1[ch_r], sx2[ch_r], sy1[ch_r], sy2[ch_r],
			loudness_pkg::SHELF_B0, loudness_pkg::SHELF_B1, loudness_pkg::SHELF_B2,
			loudness_pkg::SHELF_A1, loudness_pkg::SHELF_A2);
		hp_c = biquad(shelf_y_r, hx1[ch_r], hx2[ch_r], hy1[ch_r], hy2[ch_r],
			loudness_pkg::HPF_B0, loudness_pkg::HPF_B1, loudness_pkg::HPF_B2,
			loudness_pkg::HPF_A1, loudness_pkg::HPF_A2);
	end

	// A disabled channel keeps its history frozen, so re-enabling it starts with a short transient
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			for (int c = 0; c < loudness_pkg::NCH; c++) begin
				sx1[c] <= '0;
				sx2[c] <= '0;
				sy1[c] <= '0;
				sy2[c] <= '0;
				hx1[c] <= '0;
				hx2[c] <= '0;
				hy1[c] <= '0;
				hy2[c] <= '0;
			end
			shelf_y_r <= '0;
			hp_y_r <= '0;
		end else if (fs_r == F_SHELF && ch_enable_i[ch_r]) begin
			sx2[ch_r] <= sx1[ch_r];
			sx1[ch_r] <= x_c;
			sy2[ch_r] <= sy1[ch_r];
			sy1[ch_r] <= shelf_c;
			shelf_y_r <= shelf_c;
		end else if (fs_r == F_HPF) begin
			hx2[ch_r] <= hx1[ch_r];
			hx1[ch_r] <= shelf_y_r;
			hy2[ch_r] <= hy1[ch_r];
			hy1[ch_r] <= hp_c;
			hp_y_r <= hp_c;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Energy accumulation in quarter blocks

	energy_type sq_c;
	energy_type wsq_c;
	energy_type blk_c;
	energy_type qacc_r;
	energy_type qring_r [loudness_pkg::QUARTERS];
	energy_type tot_e_r;
	energy_type blk_sum_r;
	logic [1:0] qidx_r;
	logic [loudness_pkg::BCW-1:0] nq_r;

	always_comb begin
		// Widen before squaring, or the product keeps only the operand width
		sq_c = (energy_type'(hp_y_r) * energy_type'(hp_y_r)) >> loudness_pkg::SQ_SHIFT;
		wsq_c = energy_type'((sq_c * energy_type'(loudness_pkg::CH_WEIGHT_Q8[ch_r])) >> loudness_pkg::GFRAC);
		blk_c = qacc_r;
		for (int k = 0; k < loudness_pkg::QUARTERS; k++) begin
			if (2'(k) != qidx_r) begin
				blk_c = blk_c + qring_r[k];
			end
		end
	end

	// The running quarter is dropped at the interval end, so only whole quarters count
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			qacc_r <= '0;
			scount_r <= '0;
			qidx_r <= '0;
			qfill_r <= '0;
			tot_e_r <= '0;
			nq_r <= '0;
			blk_sum_r <= '0;
			for (int k = 0; k < loudness_pkg::QUARTERS; k++) begin
				qring_r[k] <= '0;
			end
		end else if (fs_r == F_ACC) begin
			qacc_r <= qacc_r + wsq_c;
		end else if (fs_r == F_QTR) begin
			if (quarter_end) begin
				qring_r[qidx_r] <= qacc_r;
				qidx_r <= qidx_r + 2'h1;
				qacc_r <= '0;
				scount_r <= '0;
				tot_e_r <= tot_e_r + qacc_r;
				nq_r <= nq_r + 1'b1;
				if (qfill_r == 2'h3) begin
					blk_sum_r <= blk_c;
				end else begin
					qfill_r <= qfill_r + 2'h1;
				end
			end else begin
				scount_r <= scount_r + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Block loudness and histogram of passing blocks

	loud_type blk_loud_r;
	loud_type bin_dist;
	loud_type bin_shift;
	logic [loudness_pkg::BW-1:0] blk_bin;
	energy_type bin_e [loudness_pkg::NBINS];
	logic [loudness_pkg::BCW-1:0] bin_n [loudness_pkg::NBINS];

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			blk_loud_r <= loudness_pkg::LOG_ZERO_Q;
			block_valid_o <= 1'b0;
		end else begin
			// A silent block stays at the floor; adding the offset would wrap it above the gate
			if (fs_r == F_BLK && blk_sum_r == '0) begin
				blk_loud_r <= loudness_pkg::LOG_ZERO_Q;
			end else if (fs_r == F_BLK) begin
				blk_loud_r <= log10x10(blk_sum_r) + BLK_OFFSET_Q;
			end
			block_valid_o <= (fs_r == F_BLK);
		end
	end

	assign block_loudness_o = blk_loud_r;

	always_comb begin
		bin_dist = blk_loud_r - loudness_pkg::ABS_THR_Q - loudness_pkg::LSB_Q;
		bin_shift = bin_dist >>> loudness_pkg::BIN_SHIFT;
		if (bin_shift >= loud_type'(loudness_pkg::NBINS)) begin
			blk_bin = loudness_pkg::BW'(loudness_pkg::NBINS - 1);
		end else begin
			blk_bin = bin_shift[loudness_pkg::BW-1:0];
		end
	end

	// Relative gate decisions resolve to a quarter unit; bins store energy, not loudness
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			for (int b = 0; b < loudness_pkg::NBINS; b++) begin
				bin_e[b] <= '0;
				bin_n[b] <= '0;
			end
		end else if (fs_r == F_HIST && blk_loud_r > loudness_pkg::ABS_THR_Q) begin
			bin_e[blk_bin] <= bin_e[blk_bin] + blk_sum_r;
			bin_n[blk_bin] <= bin_n[blk_bin] + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Two pass gating at the end of the interval

	gate_state_type gs_r;
	logic [loudness_pkg::BW-1:0] bi_r;
	logic [loudness_pkg::BW-1:0] start_r;
	logic [loudness_pkg::BW-1:0] start_c;
	energy_type e_sum_r;
	logic [loudness_pkg::BCW-1:0] n_sum_r;
	logic pass1_empty_r;
	loud_type mean_c;
	loud_type rel_c;
	loud_type rel_dist;
	loud_type ungated_c;

	always_comb begin
		mean_c = log10x10(e_sum_r) - log10x10(energy_type'(n_sum_r)) + BLK_OFFSET_Q;
		rel_c = mean_c - loudness_pkg::REL_DROP_Q;
		rel_dist = (rel_c - loudness_pkg::ABS_THR_Q + loudness_pkg::BIN_ROUND_Q) >>> loudness_pkg::BIN_SHIFT;
		if (rel_c <= loudness_pkg::ABS_THR_Q) begin
			start_c = '0;
		end else if (rel_dist >= loud_type'(loudness_pkg::NBINS - 1)) begin
			start_c = loudness_pkg::BW'(loudness_pkg::NBINS - 1);
		end else begin
			start_c = rel_dist[loudness_pkg::BW-1:0];
		end
		if (tot_e_r == '0) begin
			ungated_c = loudness_pkg::LOG_ZERO_Q;
		end else begin
			ungated_c = log10x10(tot_e_r) - log10x10(energy_type'(nq_r)) + BLK_OFFSET_Q
				+ loudness_pkg::QUARTER_ADJ_Q;
		end
	end

	assign gate_busy_o = (gs_r != G_IDLE);

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			gs_r <= G_IDLE;
			bi_r <= '0;
			start_r <= '0;
			e_sum_r <= '0;
			n_sum_r <= '0;
			pass1_empty_r <= 1'b1;
		end else begin
			unique case (gs_r)
				G_IDLE: begin
					if (meas_end_i) begin
						bi_r <= '0;
						e_sum_r <= '0;
						n_sum_r <= '0;
						gs_r <= G_SUM1;
					end
				end
				G_SUM1: begin
					e_sum_r <= e_sum_r + bin_e[bi_r];
					n_sum_r <= n_sum_r + bin_n[bi_r];
					if (bi_r == loudness_pkg::BW'(loudness_pkg::NBINS - 1)) begin
						gs_r <= G_THR;
					end else begin
						bi_r <= bi_r + 1'b1;
					end
				end
				G_THR: begin
					start_r <= start_c;
					pass1_empty_r <= (n_sum_r == '0);
					bi_r <= '0;
					e_sum_r <= '0;
					n_sum_r <= '0;
					gs_r <= G_SUM2;
				end
				G_SUM2: begin
					if (bi_r >= start_r) begin
						e_sum_r <= e_sum_r + bin_e[bi_r];
						n_sum_r <= n_sum_r + bin_n[bi_r];
					end
					if (bi_r == loudness_pkg::BW'(loudness_pkg::NBINS - 1)) begin
						gs_r <= G_OUT;
					end else begin
						bi_r <= bi_r + 1'b1;
					end
				end
				G_OUT: gs_r <= G_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			gated_loudness_o <= loudness_pkg::LOG_ZERO_Q;
			ungated_loudness_o <= loudness_pkg::LOG_ZERO_Q;
			gated_invalid_o <= 1'b1;
			ungated_invalid_o <= 1'b1;
			result_valid_o <= 1'b0;
		end else begin
			result_valid_o <= (gs_r == G_OUT);
			if (gs_r == G_OUT) begin
				gated_invalid_o <= pass1_empty_r || (n_sum_r == '0);
				gated_loudness_o <= (pass1_empty_r || n_sum_r == '0) ? loudness_pkg::LOG_ZERO_Q : mean_c;
				ungated_invalid_o <= (nq_r < loudness_pkg::BCW'(loudness_pkg::QUARTERS));
				ungated_loudness_o <= (nq_r < loudness_pkg::BCW'(loudness_pkg::QUARTERS)) ?
					loudness_pkg::LOG_ZERO_Q : ungated_c;
			end
		end
	end

endmodule
